/* File: core/smsf_pkg.sv */
// constants, register map and carrier types of the spi status flag block
package smsf_pkg;

    // fifo geometry
    localparam int          CNT_W         = 6;
    localparam int          FIFO_DEPTH    = 32;

    // register byte offsets
    localparam logic [7:0]  OFF_STATUS    = 8'h10;
    localparam logic [7:0]  OFF_CONTROL   = 8'h14;
    localparam logic [7:0]  OFF_MASK      = 8'h18;
    localparam logic [7:0]  OFF_LINK_CNT  = 8'h1c;

    // status bit positions
    localparam int          ST_DESC_LSB   = 24;
    localparam int          ST_DESC_MSB   = 27;
    localparam int          ST_ACTIVE     = 16;
    localparam int          ST_RX_STALL   = 15;
    localparam int          ST_RX_REQ     = 14;
    localparam int          ST_RX_EMPTY   = 13;
    localparam int          ST_RX_FULL    = 12;
    localparam int          ST_TX_STALL   = 11;
    localparam int          ST_TX_REQ     = 10;
    localparam int          ST_TX_EMPTY   = 9;
    localparam int          ST_TX_FULL    = 8;
    localparam int          ST_PROG_ERR   = 4;

    // control fields
    localparam int          CT_MODE_LSB   = 0;
    localparam int          CT_TXEN_LSB   = 2;
    localparam int          CT_RXEN       = 4;
    localparam int          CT_DESC_EN    = 5;
    localparam int          CT_TXTRG_LSB  = 8;
    localparam int          CT_RXTRG_LSB  = 16;

    // reset values
    localparam logic        RST_RX_EMPTY  = 1'b1;
    localparam logic        RST_TX_EMPTY  = 1'b0;
    localparam logic [31:0] RST_CONTROL   = 32'h0000_0000;
    localparam logic [31:0] RST_MASK      = 32'h0000_0000;

    // interface modes
    localparam logic [1:0]  MODE_SINGLE   = 2'h0;
    localparam logic [1:0]  MODE_RSVD     = 2'h3;
    localparam logic [1:0]  TXEN_OFF      = 2'h0;

    // sticky bits that software can clear, plus the level-driven transmit request, which ignores the clear
    localparam logic [31:0] W1C_BITS      = 32'h0000_cc10;

    typedef logic [CNT_W-1:0] smsf_cnt_t;

    // state reported by the serial engine, same clock
    typedef struct packed {
        logic [3:0] desc_idx;
        logic       xfer_active;
        logic       rx_stall;
        logic       tx_stall;
        smsf_cnt_t  rx_count;
        smsf_cnt_t  tx_count;
    } smsf_engine_s;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } smsf_bus_s;

endpackage

/* File: core/smsf_sync.sv */
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module smsf_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // first stage is read only by the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule

/* File: core/smsf_status.sv */
// status register, control, mask and interrupt logic of the quad serial master
`timescale 1ns/1ps
module smsf_status #(
    parameter int FIFO_DEPTH = smsf_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RSTN,
    // register port
    input  wire smsf_pkg::smsf_bus_s   BUS,
    output logic [31:0]                RDATA,
    // serial engine state
    input  wire smsf_pkg::smsf_engine_s ENGINE,
    // serial clock pin as seen on the link
    input  wire logic                  SCLK_IN,
    // interrupt
    output logic                       IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [31:0]         control_r;
    logic [31:0]         mask_r;
    logic [31:0]         rdata_r;
    logic                irq_r;

    logic [3:0]          desc_idx_r;
    logic                active_r;
    logic                rx_stall_r;
    logic                rx_req_r;
    logic                rx_empty_r;
    logic                rx_full_r;
    logic                tx_stall_r;
    logic                tx_req_r;
    logic                tx_empty_r;
    logic                tx_full_r;
    logic                prog_err_r;

    logic                sclk_sync;
    logic                sclk_prev_r;
    logic                sclk_rise;
    logic [31:0]         link_cnt_r;
    logic                active_prev_r;

    logic [31:0]         status;
    logic [31:0]         clr;
    logic                wr_status;
    logic                wr_control;
    logic                wr_mask;
    logic [1:0]          mode;
    logic [1:0]          tx_en;
    logic                rx_en;
    logic                desc_en;
    smsf_pkg::smsf_cnt_t tx_trig;
    smsf_pkg::smsf_cnt_t rx_trig;
    logic                rx_at_mark;
    logic                tx_at_mark;
    logic                bad_setting;
    logic                bad_setting_prev_r;
    logic [31:0]         pending;

    localparam smsf_pkg::smsf_cnt_t DEPTH_CNT = smsf_pkg::smsf_cnt_t'(FIFO_DEPTH);
    localparam smsf_pkg::smsf_cnt_t ZERO_CNT  = '0;

    ////////////////////////////////////////////////////////////////////////
    // write decode

    assign wr_status  = BUS.wr && (BUS.addr == smsf_pkg::OFF_STATUS);
    assign wr_control = BUS.wr && (BUS.addr == smsf_pkg::OFF_CONTROL);
    assign wr_mask    = BUS.wr && (BUS.addr == smsf_pkg::OFF_MASK);

    // only ones written onto clearable bits count; zeros and read-only bits drop out
    assign clr = wr_status ? (BUS.wdata & smsf_pkg::W1C_BITS) : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // control fields

    assign mode    = control_r[smsf_pkg::CT_MODE_LSB +: 2];
    assign tx_en   = control_r[smsf_pkg::CT_TXEN_LSB +: 2];
    assign rx_en   = control_r[smsf_pkg::CT_RXEN];
    assign desc_en = control_r[smsf_pkg::CT_DESC_EN];
    assign tx_trig = control_r[smsf_pkg::CT_TXTRG_LSB +: smsf_pkg::CNT_W];
    assign rx_trig = control_r[smsf_pkg::CT_RXTRG_LSB +: smsf_pkg::CNT_W];

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            control_r <= smsf_pkg::RST_CONTROL;
        end else if (wr_control) begin
            control_r <= BUS.wdata;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            mask_r <= smsf_pkg::RST_MASK;
        end else if (wr_mask) begin
            mask_r <= BUS.wdata & smsf_pkg::W1C_BITS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // engine state mirrors

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            desc_idx_r <= 4'h0;
        end else begin
            // index has no meaning outside descriptor mode, so it reads zero there
            desc_idx_r <= desc_en ? ENGINE.desc_idx : 4'h0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            active_r <= 1'b0;
        end else begin
            active_r <= ENGINE.xfer_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fifo level flags

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rx_empty_r <= smsf_pkg::RST_RX_EMPTY;
            rx_full_r  <= 1'b0;
        end else begin
            rx_empty_r <= (ENGINE.rx_count == ZERO_CNT);
            rx_full_r  <= (ENGINE.rx_count >= DEPTH_CNT);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            tx_empty_r <= smsf_pkg::RST_TX_EMPTY;
            tx_full_r  <= 1'b0;
        end else begin
            tx_empty_r <= (ENGINE.tx_count == ZERO_CNT);
            tx_full_r  <= (ENGINE.tx_count >= DEPTH_CNT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stall flags: an event in the clearing cycle wins over the clear

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rx_stall_r <= 1'b0;
        end else begin
            rx_stall_r <= ENGINE.rx_stall | (rx_stall_r & ~clr[smsf_pkg::ST_RX_STALL]);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            tx_stall_r <= 1'b0;
        end else begin
            tx_stall_r <= ENGINE.tx_stall | (tx_stall_r & ~clr[smsf_pkg::ST_TX_STALL]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // water-mark requests

    assign rx_at_mark = (ENGINE.rx_count >= rx_trig);
    assign tx_at_mark = (ENGINE.tx_count <= tx_trig);

    // clearing only sticks once the receive count has dropped below the mark
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rx_req_r <= 1'b0;
        end else begin
            rx_req_r <= rx_at_mark | (rx_req_r & ~clr[smsf_pkg::ST_RX_REQ]);
        end
    end

    // transmit request follows the level and ignores a clear, so it reads set whenever at the mark
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            tx_req_r <= 1'b0;
        end else if (!tx_at_mark) begin
            tx_req_r <= 1'b0;
        end else begin
            tx_req_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // programming error detection

    // reserved mode, or dual/quad with both directions enabled
    assign bad_setting = (mode == smsf_pkg::MODE_RSVD) ||
                         ((mode != smsf_pkg::MODE_SINGLE) && (tx_en != smsf_pkg::TXEN_OFF)
                          && rx_en);

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            bad_setting_prev_r <= 1'b0;
        end else begin
            bad_setting_prev_r <= bad_setting;
        end
    end

    // set on entry into a bad setting, so a clear while it persists is honoured
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            prog_err_r <= 1'b0;
        end else begin
            prog_err_r <= (bad_setting & ~bad_setting_prev_r)
                          | (prog_err_r & ~clr[smsf_pkg::ST_PROG_ERR]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link clock observation

    smsf_sync #(
        .W (1)
    ) u_sclk_sync (
        .clk   (CLK),
        .rst_n (RSTN),
        .d     (SCLK_IN),
        .q     (sclk_sync)
    );

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            sclk_prev_r   <= 1'b0;
            active_prev_r <= 1'b0;
        end else begin
            sclk_prev_r   <= sclk_sync;
            active_prev_r <= active_r;
        end
    end

    assign sclk_rise = sclk_sync & ~sclk_prev_r;

    // serial clock edges of the current transfer; restarts when a transfer begins
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            link_cnt_r <= 32'h0000_0000;
        end else if (active_r && !active_prev_r) begin
            link_cnt_r <= 32'h0000_0000;
        end else if (active_r && sclk_rise) begin
            link_cnt_r <= link_cnt_r + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status image

    always_comb begin
        status                                          = 32'h0000_0000;
        status[smsf_pkg::ST_DESC_MSB:smsf_pkg::ST_DESC_LSB] = desc_idx_r;
        status[smsf_pkg::ST_ACTIVE]                     = active_r;
        status[smsf_pkg::ST_RX_STALL]                   = rx_stall_r;
        status[smsf_pkg::ST_RX_REQ]                     = rx_req_r;
        status[smsf_pkg::ST_RX_EMPTY]                   = rx_empty_r;
        status[smsf_pkg::ST_RX_FULL]                    = rx_full_r;
        status[smsf_pkg::ST_TX_STALL]                   = tx_stall_r;
        status[smsf_pkg::ST_TX_REQ]                     = tx_req_r;
        status[smsf_pkg::ST_TX_EMPTY]                   = tx_empty_r;
        status[smsf_pkg::ST_TX_FULL]                    = tx_full_r;
        status[smsf_pkg::ST_PROG_ERR]                   = prog_err_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data valid only in the cycle after the strobe

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rdata_r <= 32'h0000_0000;
        end else if (BUS.rd) begin
            unique case (BUS.addr)
                smsf_pkg::OFF_STATUS:   rdata_r <= status;
                smsf_pkg::OFF_CONTROL:  rdata_r <= control_r;
                smsf_pkg::OFF_MASK:     rdata_r <= mask_r;
                smsf_pkg::OFF_LINK_CNT: rdata_r <= link_cnt_r;
                default:                rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt: level, high one cycle after any unmasked W1C_BITS status bit is set

    // one pending term per status bit; read-only bits can never raise the line
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_pending
            assign pending[gi] = status[gi] & mask_r[gi] & smsf_pkg::W1C_BITS[gi];
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |pending;
        end
    end

    assign RDATA = rdata_r;
    assign IRQ   = irq_r;

endmodule

/* File: bench/smsf_status_asserts.sv */
// port checker of the status flag block
`timescale 1ns/1ps
module smsf_status_chk #(
    parameter int FIFO_DEPTH = 32
) (
    // clock and reset
    input wire logic                   CLK,
    input wire logic                   RSTN,
    // register port
    input wire smsf_pkg::smsf_bus_s    BUS,
    input wire logic [31:0]            RDATA,
    // engine, link and interrupt
    input wire smsf_pkg::smsf_engine_s ENGINE,
    input wire logic                   SCLK_IN,
    input wire logic                   IRQ
);
    smsf_pkg::smsf_engine_s e1_r;
    smsf_pkg::smsf_engine_s e2_r;
    logic [31:0]            ctl_r;
    logic [31:0]            msk_r;
    logic                   st_r;
    logic                   um_r;
    logic                   ok1_r;
    logic                   ok2_r;
    wire                    st_ok = st_r && ok1_r && ok2_r;
    wire  [5:0]             txt = ctl_r[smsf_pkg::CT_TXTRG_LSB +: 6];

    ////////////////////////////////////////////////////////////////////////////////
    // a status read returns flags taken from the engine two edges earlier
    always_ff @(posedge CLK) begin
        e1_r  <= ENGINE;
        e2_r  <= e1_r;
        ok1_r <= RSTN;
        ok2_r <= ok1_r;
        st_r  <= BUS.rd && BUS.addr == smsf_pkg::OFF_STATUS;
        um_r  <= BUS.rd && !(BUS.addr inside {8'h10, 8'h14, 8'h18, 8'h1c});
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ctl_r <= 32'h0;
            msk_r <= 32'h0;
        end else if (BUS.wr && BUS.addr == smsf_pkg::OFF_CONTROL) begin
            ctl_r <= BUS.wdata;
        end else if (BUS.wr && BUS.addr == smsf_pkg::OFF_MASK) begin
            msk_r <= BUS.wdata & 32'h0000_cc10;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    a_rdata_idle: assert property (!$past(BUS.rd) |-> RDATA == 32'h0)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (um_r |-> RDATA == 32'h0)
        else $error("unmapped read not zero");
    a_live_flags: assert property (st_ok |->
        RDATA[16] == e2_r.xfer_active && RDATA[13] == (e2_r.rx_count == 6'h0) &&
        RDATA[12] == (e2_r.rx_count >= FIFO_DEPTH) && RDATA[9] == (e2_r.tx_count == 6'h0) &&
        RDATA[8] == (e2_r.tx_count >= FIFO_DEPTH))
        else $error("live status flags wrong");
    a_tx_request: assert property (st_ok |-> RDATA[10] == (e2_r.tx_count <= txt))
        else $error("transmit request wrong");
    a_desc_index: assert property (st_ok |->
        RDATA[27:24] == (ctl_r[smsf_pkg::CT_DESC_EN] ? e2_r.desc_idx : 4'h0))
        else $error("descriptor index wrong");
    a_reserved_zero: assert property (st_ok |->
        {RDATA[31:28], RDATA[23:17], RDATA[7:5]} == 14'h0)
        else $error("reserved status bits not zero");
    a_rx_stall_irq: assert property (ENGINE.rx_stall && msk_r[15] |-> ##2 IRQ)
        else $error("receive stall gave no interrupt");
    a_tx_stall_irq: assert property (ENGINE.tx_stall && msk_r[11] |-> ##2 IRQ)
        else $error("transmit stall gave no interrupt");
    a_irq_masked: assert property (msk_r == 32'h0 && $past(msk_r) == 32'h0 |-> !IRQ)
        else $error("interrupt with all sources masked");
    a_prog_err_irq: assert property (BUS.wr && BUS.addr == smsf_pkg::OFF_CONTROL &&
        BUS.wdata[1:0] == 2'h3 && msk_r[4] |-> ##[1:3] IRQ)
        else $error("reserved mode gave no interrupt");

    c_stall_irq: cover property (ENGINE.rx_stall && msk_r[15] ##2 IRQ);
    c_link_read: cover property (BUS.rd && BUS.addr == smsf_pkg::OFF_LINK_CNT);
    c_prog_err: cover property ($rose(IRQ) && msk_r[4]);
endmodule

bind smsf_status smsf_status_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.CLK(CLK), .RSTN(RSTN),
    .BUS(BUS), .RDATA(RDATA), .ENGINE(ENGINE), .SCLK_IN(SCLK_IN), .IRQ(IRQ));

/* File: bench/smsf_link_model.sv */
// serial clock source standing for the far side of the link
`timescale 1ns/1ps
module smsf_link_model (
    // frame request
    input  wire logic run,
    // clock toward the block and its count of rising edges
    output logic      sclk,
    output int        n_edges
);
    initial begin
        sclk    = 1'b0;
        n_edges = 0;
        // odd offset keeps the link phase apart from the system clock
        #3;
        forever begin
            #40;
            // stands low between frames; a started high half is finished
            if (run || sclk) begin
                sclk = ~sclk;
                if (sclk) n_edges++;
            end
        end
    end
endmodule

/* File: bench/test_spi_master_status_flags.sv */
// self-checking bench of the spi status flag block
`timescale 1ns/1ps
module test_spi_master_status_flags;
    localparam logic [7:0] ST = smsf_pkg::OFF_STATUS;
    localparam logic [7:0] CT = smsf_pkg::OFF_CONTROL;
    localparam logic [7:0] MK = smsf_pkg::OFF_MASK;
    logic                   clk;
    logic                   rstn;
    logic                   run;
    logic                   irq;
    logic                   sclk;
    logic [31:0]            rdata;
    smsf_pkg::smsf_bus_s    bus;
    smsf_pkg::smsf_engine_s eng;
    int                     n_edges;
    int                     n_fail = 0;
    int                     n_compared = 0;
    int                     cyc = 0;

    smsf_status dut (.CLK(clk), .RSTN(rstn), .BUS(bus), .RDATA(rdata), .ENGINE(eng),
        .SCLK_IN(sclk), .IRQ(irq));
    smsf_link_model link (.run(run), .sclk(sclk), .n_edges(n_edges));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic st(input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        rd(ST, v);
        chk(v & m, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_live();
        logic [5:0]  rc [4] = '{6'h00, 6'h20, 6'h01, 6'h1f};
        logic [5:0]  tc [4] = '{6'h00, 6'h05, 6'h04, 6'h20};
        logic [31:0] e;
        logic [31:0] v;
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, v);
        chk(v, 32'h0);
        wr(CT, 32'h0008_0400);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            eng.rx_count    <= rc[i];
            eng.tx_count    <= tc[i];
            eng.xfer_active <= i[0];
            e     = 32'h0;
            e[16] = i[0];
            e[13] = rc[i] == 6'h00;
            e[12] = rc[i] >= 6'h20;
            e[10] = tc[i] <= 6'h04;
            e[9]  = tc[i] == 6'h00;
            e[8]  = tc[i] >= 6'h20;
            st(32'h0001_3700, e);
        end
        // ones on read-only bits only, no clearable bit touched
        wr(ST, 32'h0f01_3300);
        st(32'h0001_3700, e);
    endtask

    task automatic t_rx_req();
        wr(MK, 32'h0000_4000);
        @(posedge clk);
        eng.rx_count <= 6'h07;
        wr(ST, 32'h0000_4000);
        st(32'h4000, 32'h0);
        @(posedge clk);
        eng.rx_count <= 6'h08;
        st(32'h4000, 32'h4000);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        eng.rx_count <= 6'h07;
        wr(ST, 32'h0);
        st(32'h4000, 32'h4000);
        wr(ST, 32'h4000);
        st(32'h4000, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_stall();
        logic [31:0] b;
        logic [31:0] v;
        wr(MK, 32'hffff_ffff);
        rd(MK, v);
        chk(v, 32'h0000_cc10);
        for (int k = 0; k < 3; k++) begin
            b = (k == 1) ? 32'h0800 : 32'h8000;
            wr(MK, (k == 2) ? 32'h0810 : 32'h8810);
            @(posedge clk);
            eng.rx_stall <= (k != 1);
            eng.tx_stall <= (k == 1);
            @(posedge clk);
            eng.rx_stall <= 1'b0;
            eng.tx_stall <= 1'b0;
            @(posedge clk);
            #1 chk({31'h0, irq}, {31'h0, k != 2});
            wr(ST, 32'h0);
            st(b, b);
            wr(ST, b);
            st(b, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
    endtask

    task automatic t_prog();
        logic [31:0] cv [4] = '{32'h0000_0003, 32'h0000_0015, 32'h0000_0016, 32'h0000_0005};
        wr(MK, 32'h0000_0010);
        for (int i = 0; i < 4; i++) begin
            wr(CT, cv[i]);
            st(32'h10, (i < 3) ? 32'h10 : 32'h0);
            chk({31'h0, irq}, {31'h0, i < 3});
            wr(CT, 32'h0);
            wr(ST, 32'h10);
            st(32'h10, 32'h0);
        end
    endtask

    task automatic t_desc();
        @(posedge clk);
        eng.desc_idx <= 4'ha;
        st(32'h0f00_0000, 32'h0);
        wr(CT, 32'h0000_0020);
        st(32'h0f00_0000, 32'h0a00_0000);
    endtask

    task automatic t_link();
        logic [31:0] v;
        @(posedge clk);
        eng.xfer_active <= 1'b0;
        repeat (2) @(posedge clk);
        eng.xfer_active <= 1'b1;
        repeat (4) @(posedge clk);
        run <= 1'b1;
        repeat (60) @(posedge clk);
        run <= 1'b0;
        // edges reach the count three cycles late
        repeat (20) @(posedge clk);
        rd(smsf_pkg::OFF_LINK_CNT, v);
        chk(v, 32'(n_edges));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        run  = 1'b0;
        bus  = '0;
        eng  = '0;
        repeat (4) @(posedge clk);
        rstn     <= 1'b1;
        bus.addr <= ST;
        bus.rd   <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, 32'h0000_2000);
        st(32'hffff_fff0, 32'h0000_6600);
        t_live();
        t_rx_req();
        t_stall();
        t_prog();
        t_desc();
        t_link();
        results();
    end
endmodule
